// ===== logic/rhc_port.sv
// remote host configuration port top
//
// Notes on behaviour
// - the config register is reached only by the host with command strobe and access enable high and lock low.
// - the irq status bit reads the current value of interrupt mask bit three.
// - with the irq line as output, a host write of one to the status bit toggles that output.
// - a one written to step with run low executes exactly the current instruction and advances the counter.
// - with latched write low, fast write high picks fast buffered writes, low picks slow buffered writes.
// - latched read high picks latched reads, low picks buffered reads.
// - latched write high picks latched writes, low picks buffered writes with speed from fast write.
// - setting run starts at the current counter; clearing it finishes the instruction then idles.
// - after reset step, fast and latched bits are low, run is low unless a stand-alone start is sampled, and memory select points at instruction memory.
// - read strobe, write strobe and reset together with access enable low make the processor come out running.
// - memory select routes accesses: 00 data, 01 instruction, 10 counter low, 11 counter high.
// - every remote access uses the same mode bits whatever the target.
// - on simultaneous data requests the processor wins first, then grants alternate unless locked.
`timescale 1ns/1ps
module rhc_port (
  input  wire logic                 CLOCK_I,
  input  wire logic                 RESET_N_I,
  input  wire logic                 CMD_I,
  input  wire logic                 REMOTE_ACCESS_ENABLE_N_I,
  input  wire logic                 REMOTE_READ_STROBE_N_I,
  input  wire logic                 REMOTE_WRITE_STROBE_N_I,
  input  wire logic [7:0]           HOST_DATA_I,
  output logic      [7:0]           HOST_DATA_O,
  output logic                      HOST_DATA_OE_N_O,
  input  wire logic                 LOCAL_ONLY_REMOTE_LOCK_I,
  input  wire logic                 CPU_LOCK_I,
  input  wire logic                 INTERRUPT_MASK_THREE_I,
  input  wire logic                 BIDIR_IRQ_IS_OUTPUT_I,
  output logic                      IRQ_TOGGLE_O,
  input  wire logic                 INSTR_DONE_I,
  output logic                      CPU_RUN_O,
  output logic [rhc_pkg::PC_WIDTH-1:0] PC_O,
  input  wire logic                 PC_ADVANCE_I,
  input  wire logic                 CPU_DMEM_REQ_I,
  input  wire logic                 CYCLE_END_I,
  output logic                      CPU_DMEM_GRANT_O,
  output logic                      HOST_DMEM_GRANT_O,
  output logic                      SEL_DATA_MEM_O,
  output logic                      SEL_INSTR_MEM_O,
  output logic                      SEL_PC_LOW_O,
  output logic                      SEL_PC_HIGH_O,
  output logic                      LATCHED_READ_O,
  output rhc_pkg::rhc_wmode_e       WRITE_MODE_O
);
  import rhc_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [2:0]          rae_sync;
    logic [2:0]          rd_sync;
    logic [2:0]          wr_sync;
    logic [2:0]          cmd_sync;
    logic [15:0]         din_sync;
    logic                step;
    logic                fast_write;
    logic                latched_read;
    logic                latched_write;
    logic                run_control;
    logic [1:0]          msel;
    logic                in_reset;
    logic                standalone;
    rhc_run_e            run_state;
    logic [PC_WIDTH-1:0] pc;
    logic [7:0]          rdata;
    logic                rd_active;
    logic                irq_toggle;
  } rhc_port_s;
  rhc_port_s st_reg;
  rhc_port_s st_next;

  logic rae_n;
  logic rd_n;
  logic wr_n;
  logic cmd;
  logic cfg_access;
  logic wr_edge;
  logic rd_edge;
  logic host_dmem_req;
  logic [7:0] cfg_read;
  logic [7:0] din;

  // second stages only; bit 0 is the first synchroniser stage
  assign rae_n = st_reg.rae_sync[1];
  assign rd_n  = st_reg.rd_sync[1];
  assign wr_n  = st_reg.wr_sync[1];
  assign cmd   = st_reg.cmd_sync[1];
  // host data passes two stages like the strobes
  assign din   = st_reg.din_sync[15:8];
  assign wr_edge = !st_reg.wr_sync[1] && st_reg.wr_sync[2];
  assign rd_edge = !st_reg.rd_sync[1] && st_reg.rd_sync[2];

  assign cfg_access = cmd && !rae_n && !LOCAL_ONLY_REMOTE_LOCK_I;

  // status bit mirrors mask bit three
  always_comb begin
    cfg_read = {INTERRUPT_MASK_THREE_I, st_reg.step, st_reg.fast_write, st_reg.latched_read,
                st_reg.latched_write, st_reg.run_control, st_reg.msel};
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.rae_sync = {st_reg.rae_sync[1:0], REMOTE_ACCESS_ENABLE_N_I};
    st_next.rd_sync  = {st_reg.rd_sync[1:0], REMOTE_READ_STROBE_N_I};
    st_next.wr_sync  = {st_reg.wr_sync[1:0], REMOTE_WRITE_STROBE_N_I};
    st_next.cmd_sync = {st_reg.cmd_sync[1:0], CMD_I};
    st_next.din_sync = {st_reg.din_sync[7:0], HOST_DATA_I};
    st_next.in_reset = 1'b0;
    st_next.rd_active = !rd_n && !rae_n;
    if (st_reg.in_reset) begin
      // stand-alone start sampled at reset release
      st_next.run_control = st_reg.standalone;
    end
    st_next.step = 1'b0;
    if (cfg_access && wr_edge) begin
      st_next.step          = din[CFG_BIT_STEP];
      st_next.fast_write    = din[CFG_BIT_FAST_WRITE];
      st_next.latched_read  = din[CFG_BIT_LATCH_RD];
      st_next.latched_write = din[CFG_BIT_LATCH_WR];
      st_next.run_control   = din[CFG_BIT_RUN];
      st_next.msel          = din[CFG_BIT_MSEL_HI:CFG_BIT_MSEL_LO];
      // toggle irq output on write of one; ignored when line is input
      if (din[CFG_BIT_IRQ_STATUS] && BIDIR_IRQ_IS_OUTPUT_I) begin
        st_next.irq_toggle = !st_reg.irq_toggle;
      end
    end
    // host writes to counter bytes, only when idle
    if (!cmd && !rae_n && wr_edge && st_reg.run_state == RUN_IDLE) begin
      if (st_reg.msel == MSEL_PC_LOW) begin
        st_next.pc[7:0] = din;
      end else if (st_reg.msel == MSEL_PC_HIGH) begin
        st_next.pc[PC_WIDTH-1:8] = din;
      end
    end
    if (rd_edge) begin
      if (cfg_access) begin
        st_next.rdata = cfg_read;
      end else if (st_reg.msel == MSEL_PC_LOW) begin
        st_next.rdata = st_reg.pc[7:0];
      end else begin
        st_next.rdata = st_reg.pc[PC_WIDTH-1:8];
      end
    end
    if (PC_ADVANCE_I && st_reg.run_state != RUN_IDLE) begin
      st_next.pc = st_reg.pc + 16'h0001;
    end
    // run, stop after instruction, single step
    case (st_reg.run_state)
      RUN_IDLE: begin
        if (st_reg.run_control) begin
          st_next.run_state = RUN_EXEC;
        end else if (st_reg.step) begin
          st_next.run_state = RUN_STEP;
        end
      end
      RUN_EXEC: begin
        if (!st_reg.run_control && INSTR_DONE_I) begin
          st_next.run_state = RUN_IDLE;
        end
      end
      RUN_STEP: begin
        if (INSTR_DONE_I) begin
          st_next.run_state = st_reg.run_control ? RUN_EXEC : RUN_IDLE;
        end
      end
      default: begin
        st_next.run_state = RUN_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      st_reg            <= '0;
      st_reg.rae_sync   <= 3'h7;
      st_reg.rd_sync    <= 3'h7;
      st_reg.wr_sync    <= 3'h7;
      st_reg.msel       <= MSEL_RESET;
      st_reg.pc         <= PC_RESET;
      st_reg.in_reset   <= 1'b1;
      st_reg.run_state  <= RUN_IDLE;
      st_reg.standalone <= !st_reg.rd_sync[1] && !st_reg.wr_sync[1] && st_reg.rae_sync[1];
      st_reg.rd_sync    <= {st_reg.rd_sync[1:0], REMOTE_READ_STROBE_N_I};
      st_reg.wr_sync    <= {st_reg.wr_sync[1:0], REMOTE_WRITE_STROBE_N_I};
      st_reg.rae_sync   <= {st_reg.rae_sync[1:0], REMOTE_ACCESS_ENABLE_N_I};
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign host_dmem_req = !rae_n && !cmd && (!rd_n || !wr_n) && st_reg.msel == MSEL_DATA_MEM;

  rhc_arbiter u_arb (
    .CLOCK_I      (CLOCK_I),
    .RESET_N_I    (RESET_N_I),
    .cpu_req_i    (CPU_DMEM_REQ_I),
    .host_req_i   (host_dmem_req),
    .lock_i       (LOCAL_ONLY_REMOTE_LOCK_I || CPU_LOCK_I),
    .cycle_end_i  (CYCLE_END_I),
    .cpu_grant_o  (CPU_DMEM_GRANT_O),
    .host_grant_o (HOST_DMEM_GRANT_O)
  );

  assign HOST_DATA_O      = st_reg.rdata;
  assign HOST_DATA_OE_N_O = !st_reg.rd_active;
  assign IRQ_TOGGLE_O     = st_reg.irq_toggle;
  assign CPU_RUN_O        = st_reg.run_state != RUN_IDLE;
  assign PC_O             = st_reg.pc;
  // target decode; shared mode bits for all targets
  assign SEL_DATA_MEM_O   = st_reg.msel == MSEL_DATA_MEM;
  assign SEL_INSTR_MEM_O  = st_reg.msel == MSEL_INSTR_MEM;
  assign SEL_PC_LOW_O     = st_reg.msel == MSEL_PC_LOW;
  assign SEL_PC_HIGH_O    = st_reg.msel == MSEL_PC_HIGH;
  assign LATCHED_READ_O   = st_reg.latched_read;
  assign WRITE_MODE_O     = st_reg.latched_write ? WR_LATCHED : (st_reg.fast_write ? WR_FAST_BUF : WR_SLOW_BUF);

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_step_req;
    st_reg.step && st_reg.run_state == RUN_IDLE && !st_reg.run_control;
  endsequence
  sequence s_step_done;
    st_reg.run_state == RUN_STEP && INSTR_DONE_I && !st_reg.run_control;
  endsequence
  a_step_enter: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    s_step_req |=> st_reg.run_state == RUN_STEP)
    else $error("step request not taken");
  a_step_single: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    s_step_done |=> st_reg.run_state == RUN_IDLE)
    else $error("step did not stop after one instruction");
  a_stop_on_done: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    (st_reg.run_state == RUN_EXEC && !st_reg.run_control && INSTR_DONE_I) |=> !CPU_RUN_O)
    else $error("no halt after instruction");
  a_start_run: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    (st_reg.run_state == RUN_IDLE && st_reg.run_control) |=> CPU_RUN_O)
    else $error("run bit did not start");
  a_cfg_locked: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    (LOCAL_ONLY_REMOTE_LOCK_I && !st_reg.in_reset) |=> $stable(st_reg.msel))
    else $error("config changed while locked");
  a_irq_input_hold: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    !BIDIR_IRQ_IS_OUTPUT_I |=> $stable(IRQ_TOGGLE_O))
    else $error("irq toggled while input");
  a_irq_toggle: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    (cfg_access && wr_edge && din[CFG_BIT_IRQ_STATUS] && BIDIR_IRQ_IS_OUTPUT_I)
      |=> IRQ_TOGGLE_O != $past(IRQ_TOGGLE_O))
    else $error("irq output not toggled");
  a_status_mirror: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    (rd_edge && cfg_access) |=> HOST_DATA_O[CFG_BIT_IRQ_STATUS] == $past(INTERRUPT_MASK_THREE_I))
    else $error("status does not mirror mask");
  a_reset_values: assert property (@(posedge CLOCK_I)
    $rose(RESET_N_I) |-> st_reg.msel == MSEL_INSTR_MEM && !st_reg.latched_read && !st_reg.fast_write
      && !st_reg.latched_write && !st_reg.run_control && !st_reg.step)
    else $error("bad reset values");
  a_write_mode: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    (cfg_access && wr_edge && !din[CFG_BIT_LATCH_WR] && din[CFG_BIT_FAST_WRITE]) |=> WRITE_MODE_O == WR_FAST_BUF)
    else $error("fast write not selected");
  a_latched_write: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    (cfg_access && wr_edge && din[CFG_BIT_LATCH_WR]) |=> WRITE_MODE_O == WR_LATCHED)
    else $error("latched write not selected");
  a_read_mode: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    (cfg_access && wr_edge) |=> LATCHED_READ_O == $past(din[CFG_BIT_LATCH_RD]))
    else $error("read mode mismatch");
  a_msel_onehot: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    $onehot({SEL_DATA_MEM_O, SEL_INSTR_MEM_O, SEL_PC_LOW_O, SEL_PC_HIGH_O}))
    else $error("target decode not one-hot");
  a_standalone: assert property (@(posedge CLOCK_I)
    (st_reg.in_reset && st_reg.standalone && RESET_N_I) |=> st_reg.run_control)
    else $error("stand-alone start missed");
endmodule

// ===== include/rhc_pkg.sv
// package: constants and types for the remote host configuration port
package rhc_pkg;
  // ****************************************************************
  // config register field positions
  // ****************************************************************
  localparam int unsigned CFG_BIT_IRQ_STATUS = 7;
  localparam int unsigned CFG_BIT_STEP       = 6;
  localparam int unsigned CFG_BIT_FAST_WRITE = 5;
  localparam int unsigned CFG_BIT_LATCH_RD   = 4;
  localparam int unsigned CFG_BIT_LATCH_WR   = 3;
  localparam int unsigned CFG_BIT_RUN        = 2;
  localparam int unsigned CFG_BIT_MSEL_HI    = 1;
  localparam int unsigned CFG_BIT_MSEL_LO    = 0;
  // ****************************************************************
  // reset values and encodings
  // ****************************************************************
  localparam logic [1:0] MSEL_DATA_MEM  = 2'h0;
  localparam logic [1:0] MSEL_INSTR_MEM = 2'h1;
  localparam logic [1:0] MSEL_PC_LOW    = 2'h2;
  localparam logic [1:0] MSEL_PC_HIGH   = 2'h3;
  localparam logic [1:0] MSEL_RESET     = MSEL_INSTR_MEM;
  localparam logic [15:0] PC_RESET      = 16'h0000;
  localparam int unsigned PC_WIDTH      = 16;
  localparam int unsigned STEP_CYCLES   = 4;
  typedef enum logic [1:0] {WR_SLOW_BUF, WR_FAST_BUF, WR_LATCHED} rhc_wmode_e;
  typedef enum logic [1:0] {RUN_IDLE, RUN_EXEC, RUN_STEP} rhc_run_e;
endpackage

// ===== logic/rhc_arbiter.sv
// data memory arbiter between processor and remote host
`timescale 1ns/1ps
module rhc_arbiter (
  input  wire logic CLOCK_I,
  input  wire logic RESET_N_I,
  input  wire logic cpu_req_i,
  input  wire logic host_req_i,
  input  wire logic lock_i,
  input  wire logic cycle_end_i,
  output logic      cpu_grant_o,
  output logic      host_grant_o
);
  import rhc_pkg::*;
  typedef struct packed {
    logic host_turn;
  } rhc_arb_s;
  rhc_arb_s st_reg;
  rhc_arb_s st_next;

  always_comb begin
    st_next = st_reg;
    if (cpu_req_i && host_req_i) begin
      cpu_grant_o  = !st_reg.host_turn;
      host_grant_o = st_reg.host_turn;
    end else begin
      cpu_grant_o  = cpu_req_i;
      host_grant_o = host_req_i;
    end
    if (cycle_end_i && cpu_req_i && host_req_i && !lock_i) begin
      st_next.host_turn = !st_reg.host_turn;
    end
    if (!(cpu_req_i && host_req_i)) begin
      st_next.host_turn = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  a_arb_first_cpu: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    (cpu_req_i && host_req_i && !$past(cpu_req_i && host_req_i)) |-> cpu_grant_o && !host_grant_o)
    else $error("processor not granted first");
  a_arb_alternate: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    (cpu_req_i && host_req_i && cycle_end_i && !lock_i && cpu_grant_o)
      ##1 (cpu_req_i && host_req_i) |-> host_grant_o)
    else $error("grants did not alternate");
  a_arb_onehot: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    !(cpu_grant_o && host_grant_o))
    else $error("double grant");
endmodule

// ===== sim/rhc_host_model.sv
// remote host model driving the config port strobes and data bus
`timescale 1ns/1ps
module rhc_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_oe_n_i,
  output logic            cmd_o,
  output logic            access_enable_n_o,
  output logic            read_strobe_n_o,
  output logic            write_strobe_n_o,
  output logic [7:0]      wr_data_o
);
  // ****************************************************************
  // strobe tasks
  // ****************************************************************
  logic [7:0] last_data;
  initial begin
    cmd_o = 1'h0;
    access_enable_n_o = 1'h1;
    read_strobe_n_o = 1'h1;
    write_strobe_n_o = 1'h1;
    last_data = 8'h5A;
    wr_data_o = 8'hA5;
  end
  task automatic hold(input logic cmd, input logic wr, input logic [7:0] d);
    @(negedge clk_i);
    cmd_o = cmd;
    access_enable_n_o = 1'h0;
    if (wr) begin
      wr_data_o = d;
      last_data = d;
      write_strobe_n_o = 1'h0;
    end else begin
      read_strobe_n_o = 1'h0;
    end
  endtask
  // released bus shows the inverse of the last value
  task automatic release_bus();
    @(negedge clk_i);
    read_strobe_n_o = 1'h1;
    write_strobe_n_o = 1'h1;
    access_enable_n_o = 1'h1;
    cmd_o = 1'h0;
    wr_data_o = ~last_data;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic xfer(input logic cmd, input logic wr, input logic [7:0] d, output logic [7:0] q,
                      output logic oe_n);
    hold(cmd, wr, d);
    repeat (6) @(negedge clk_i);
    q = rd_data_i;
    oe_n = rd_oe_n_i;
    release_bus();
  endtask
  task automatic standalone(input logic on);
    access_enable_n_o = 1'h1;
    read_strobe_n_o = ~on;
    write_strobe_n_o = ~on;
  endtask
endmodule

// ===== sim/rhc_port_tb.sv
// self-checking testbench for the remote host configuration port
`timescale 1ns/1ps
module rhc_port_tb;
  import rhc_pkg::*;
  // ****************************************************************
  // signals, clock and instances
  // ****************************************************************
  logic CLOCK_I = 1'h0, RESET_N_I = 1'h0, CMD_I, AE_N, RD_N, WR_N, OE_N, LOCAL_ONLY_REMOTE_LOCK = 1'h0, CPU_LOCK_I = 1'h0;
  logic MASK3 = 1'h0, BIDIR_OUT = 1'h0, IRQ_TOGGLE_O, DONE = 1'h0, ADV = 1'h0, CPU_RUN_O, CREQ = 1'h0, CEND = 1'h0;
  logic CGNT, HGNT, S_D, S_I, S_L, S_H, LATCHED_READ_O, oe;
  logic [7:0] DIN, DOUT, q;
  logic [15:0] PC_O;
  rhc_wmode_e WRITE_MODE_O;
  int err_total = 0, checks = 0;
  always #50 CLOCK_I = ~CLOCK_I;
  rhc_port u_rhc_port (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .CMD_I(CMD_I), .REMOTE_ACCESS_ENABLE_N_I(AE_N),
    .REMOTE_READ_STROBE_N_I(RD_N), .REMOTE_WRITE_STROBE_N_I(WR_N), .HOST_DATA_I(DIN), .HOST_DATA_O(DOUT),
    .HOST_DATA_OE_N_O(OE_N), .LOCAL_ONLY_REMOTE_LOCK_I(LOCAL_ONLY_REMOTE_LOCK), .CPU_LOCK_I(CPU_LOCK_I), .INTERRUPT_MASK_THREE_I(MASK3),
    .BIDIR_IRQ_IS_OUTPUT_I(BIDIR_OUT), .IRQ_TOGGLE_O(IRQ_TOGGLE_O), .INSTR_DONE_I(DONE), .CPU_RUN_O(CPU_RUN_O),
    .PC_O(PC_O), .PC_ADVANCE_I(ADV), .CPU_DMEM_REQ_I(CREQ), .CYCLE_END_I(CEND), .CPU_DMEM_GRANT_O(CGNT),
    .HOST_DMEM_GRANT_O(HGNT), .SEL_DATA_MEM_O(S_D), .SEL_INSTR_MEM_O(S_I), .SEL_PC_LOW_O(S_L),
    .SEL_PC_HIGH_O(S_H), .LATCHED_READ_O(LATCHED_READ_O), .WRITE_MODE_O(WRITE_MODE_O));
  rhc_host_model u_rhc_host_model (.clk_i(CLOCK_I), .rd_data_i(DOUT), .rd_oe_n_i(OE_N), .cmd_o(CMD_I),
    .access_enable_n_o(AE_N), .read_strobe_n_o(RD_N), .write_strobe_n_o(WR_N), .wr_data_o(DIN));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] d);
    u_rhc_host_model.xfer(1'h1, 1'h1, d, q, oe);
  endtask
  task automatic rdchk(input logic [7:0] exp);
    u_rhc_host_model.xfer(1'h1, 1'h0, 8'h00, q, oe);
    check("cfg", {8'h00, q}, {8'h00, exp});
    check("oe_n", {15'h0000, oe}, 16'h0000);
  endtask
  task automatic finish_instr();
    @(negedge CLOCK_I);
    ADV = 1'h1;
    DONE = 1'h1;
    @(negedge CLOCK_I);
    ADV = 1'h0;
    DONE = 1'h0;
    repeat (2) @(negedge CLOCK_I);
  endtask
  task automatic cycle_end();
    @(negedge CLOCK_I);
    CEND = 1'h1;
    @(negedge CLOCK_I);
    CEND = 1'h0;
  endtask
  task automatic do_reset();
    repeat (3) @(negedge CLOCK_I);
    RESET_N_I = 1'h1;
  endtask
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (5000) @(posedge CLOCK_I);
    err_total++;
    wrap_up();
  end
  initial begin
    do_reset();
    repeat (4) @(negedge CLOCK_I);
    check("sel", {12'h000, S_H, S_L, S_I, S_D}, 16'h0002);
    check("run", {15'h0000, CPU_RUN_O}, 16'h0000);
    check("wmode", {14'h0000, WRITE_MODE_O}, {14'h0000, WR_SLOW_BUF});
    check("lrd", {15'h0000, LATCHED_READ_O}, 16'h0000);
    rdchk(8'h01);
    MASK3 = 1'h1;
    rdchk(8'h81);
    MASK3 = 1'h0;
    for (int i = 0; i < 4; i++) begin
      wr(8'(i));
      check("sel", {12'h000, S_H, S_L, S_I, S_D}, 16'h0001 << i);
      rdchk(8'(i));
    end
    wr(8'h20);
    check("wmode", {14'h0000, WRITE_MODE_O}, {14'h0000, WR_FAST_BUF});
    wr(8'h28);
    check("wmode", {14'h0000, WRITE_MODE_O}, {14'h0000, WR_LATCHED});
    wr(8'h10);
    check("lrd", {15'h0000, LATCHED_READ_O}, 16'h0001);
    check("wmode", {14'h0000, WRITE_MODE_O}, {14'h0000, WR_SLOW_BUF});
    LOCAL_ONLY_REMOTE_LOCK = 1'h1;
    wr(8'h03);
    LOCAL_ONLY_REMOTE_LOCK = 1'h0;
    u_rhc_host_model.xfer(1'h0, 1'h1, 8'h03, q, oe);
    rdchk(8'h10);
    BIDIR_OUT = 1'h1;
    wr(8'h80);
    check("irq", {15'h0000, IRQ_TOGGLE_O}, 16'h0001);
    BIDIR_OUT = 1'h0;
    wr(8'h80);
    check("irq", {15'h0000, IRQ_TOGGLE_O}, 16'h0001);
    wr(8'h02);
    u_rhc_host_model.xfer(1'h0, 1'h1, 8'h34, q, oe);
    wr(8'h03);
    u_rhc_host_model.xfer(1'h0, 1'h1, 8'h12, q, oe);
    check("pc", PC_O, 16'h1234);
    u_rhc_host_model.xfer(1'h0, 1'h0, 8'h00, q, oe);
    check("pc_hi", {8'h00, q}, 16'h0012);
    wr(8'h06);
    check("run", {15'h0000, CPU_RUN_O}, 16'h0001);
    u_rhc_host_model.xfer(1'h0, 1'h1, 8'h55, q, oe);
    check("pc", PC_O, 16'h1234);
    finish_instr();
    check("pc", PC_O, 16'h1235);
    wr(8'h00);
    check("run", {15'h0000, CPU_RUN_O}, 16'h0001);
    finish_instr();
    check("run", {15'h0000, CPU_RUN_O}, 16'h0000);
    wr(8'h40);
    check("run", {15'h0000, CPU_RUN_O}, 16'h0001);
    finish_instr();
    check("pc", PC_O, 16'h1237);
    check("run", {15'h0000, CPU_RUN_O}, 16'h0000);
    CREQ = 1'h1;
    u_rhc_host_model.hold(1'h0, 1'h0, 8'h00);
    repeat (6) @(negedge CLOCK_I);
    check("grant", {14'h0000, CGNT, HGNT}, 16'h0002);
    cycle_end();
    check("grant", {14'h0000, CGNT, HGNT}, 16'h0001);
    cycle_end();
    check("grant", {14'h0000, CGNT, HGNT}, 16'h0002);
    u_rhc_host_model.release_bus();
    CREQ = 1'h0;
    RESET_N_I = 1'h0;
    u_rhc_host_model.standalone(1'h1);
    do_reset();
    repeat (2) @(negedge CLOCK_I);
    check("run", {15'h0000, CPU_RUN_O}, 16'h0001);
    check("pc", PC_O, 16'h0000);
    u_rhc_host_model.standalone(1'h0);
    wrap_up();
  end
endmodule
